// ### mbrh_map.vh
`ifndef MBRH_MAP_VH
`define MBRH_MAP_VH
// function codes
`define MBRH_FC_RD_COILS 8'h01
`define MBRH_FC_RD_DISC 8'h02
`define MBRH_FC_RD_HOLD 8'h03
`define MBRH_FC_RD_INPUT 8'h04
`define MBRH_FC_WR_COIL 8'h05
`define MBRH_FC_WR_REG 8'h06
`define MBRH_FC_WR_COILS 8'h0f
`define MBRH_FC_WR_REGS 8'h10
`define MBRH_FC_MASK_WR 8'h16
`define MBRH_FC_RW_REGS 8'h17
// exception codes
`define MBRH_EX_FUNC 8'h01
`define MBRH_EX_ADDR 8'h02
`define MBRH_EX_VALUE 8'h03
`define MBRH_EX_FAIL 8'h04
// object addresses
`define MBRH_ADDR_CLK_SEC 16'h8110
`define MBRH_ADDR_CLK_MIN 16'h8111
`define MBRH_ADDR_CLK_HOUR 16'h8112
`define MBRH_ADDR_FAULT 16'he003
`define MBRH_ADDR_RUN 16'hf001
// frame fault codes
`define MBRH_FLT_ALLOC 16'h0001
`define MBRH_FLT_CSUM 16'h0002
`define MBRH_FLT_BCAST 16'h0003
`define MBRH_FLT_SIZE 16'h0004
`define MBRH_FLT_COILS 16'h0005
`define MBRH_FLT_REGS 16'h0006
`define MBRH_FLT_RW 16'h0007
`define MBRH_FLT_DMA 16'h0008
`define MBRH_FLT_QUEUE 16'h0009
// reset values
`define MBRH_RST_FAULT 16'h0000
`define MBRH_RST_AUTO 1'b1
// program store sizes
`define MBRH_GEN_LINES 59754
`define MBRH_SPC_LINES 1928
// fixed usb port settings
`define MBRH_USB_BAUD 115200
`define MBRH_USB_STATION 8'h01
`endif

// ### mbrh_handler.v
`timescale 1ns/1ns
`include "mbrh_map.vh"
module mbrh_handler #(
	parameter GEN_LINES = `MBRH_GEN_LINES,
	parameter SPC_LINES = `MBRH_SPC_LINES
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// request, one pulse per decoded frame from either port
	input wire req_valid,
	input wire req_port,
	input wire [7:0] req_func,
	input wire [15:0] req_addr,
	input wire [15:0] req_count,
	input wire [15:0] req_wdata,
	input wire [15:0] req_and_mask,
	input wire [15:0] req_or_mask,
	input wire req_fail,
	// program store write request
	input wire prog_valid,
	input wire prog_special,
	input wire [15:0] prog_line,
	// frame fault events from the framing layer
	input wire flt_alloc,
	input wire flt_csum,
	input wire flt_bcast,
	input wire flt_size,
	input wire flt_coils,
	input wire flt_regs,
	input wire flt_rw,
	input wire flt_dma,
	input wire flt_queue,
	// device state
	input wire run_state,
	input wire [15:0] rtc_sec,
	input wire [15:0] rtc_min,
	input wire [15:0] rtc_hour,
	// reply
	output reg rsp_valid,
	output reg rsp_port,
	output reg [7:0] rsp_func,
	output reg [7:0] rsp_exc,
	output reg [15:0] rsp_data,
	// clock load
	output reg rtc_load,
	output reg [15:0] rtc_set_sec,
	output reg [15:0] rtc_set_min,
	output reg [15:0] rtc_set_hour,
	// program store
	output reg prog_accept,
	output reg prog_refused,
	// visible state
	output reg [15:0] fault_code,
	output reg fault_flag
);
	reg rst_s1_reg;
	reg rst_s2_reg;
	reg auto_reg;
	reg [7:0] exc_next;
	reg [15:0] data_next;
	reg [15:0] flt_next;
	reg flt_hit;
	reg is_clk_reg;
	reg is_clk_coil;
	reg is_read;
	reg is_write_reg;
	reg addr_ok;
	wire rst_n;
	wire [15:0] masked;
	wire [15:0] sec_reg;
	wire [15:0] min_reg;
	wire [15:0] hour_reg;
	wire stage_wr;
	wire mask_op;
	reg line_fits;

	// usb port framing is fixed; its station and rate stay beside the shared handler
	localparam [7:0] USB_STATION = `MBRH_USB_STATION;
	localparam USB_BAUD = `MBRH_USB_BAUD;

	// reset release through two flops; assertion stays asynchronous
	always @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rst_s1_reg <= 1'b0;
			rst_s2_reg <= 1'b0;
		end else begin
			rst_s1_reg <= 1'b1;
			rst_s2_reg <= rst_s1_reg;
		end
	end
	assign rst_n = rst_s2_reg;

	// read-back of the currently addressed clock register; any other address selects hour
	assign masked = ((req_addr == `MBRH_ADDR_CLK_SEC) ? sec_reg :
		(req_addr == `MBRH_ADDR_CLK_MIN) ? min_reg : hour_reg);

	// a register write lands only with refresh off, else the next refresh undoes it
	assign stage_wr = req_valid && exc_next == 8'h00 && is_write_reg && !auto_reg;
	assign mask_op = (req_func == `MBRH_FC_MASK_WR);

	// the three staged clock fields share one shape
	mbrh_stage #(
		.WIDTH(16)
	) stage_sec_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.refresh(auto_reg),
		.live(rtc_sec),
		.wr(stage_wr && req_addr == `MBRH_ADDR_CLK_SEC),
		.mask_op(mask_op),
		.wdata(req_wdata),
		.and_mask(req_and_mask),
		.or_mask(req_or_mask),
		.stage_reg(sec_reg)
	);

	mbrh_stage #(
		.WIDTH(16)
	) stage_min_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.refresh(auto_reg),
		.live(rtc_min),
		.wr(stage_wr && req_addr == `MBRH_ADDR_CLK_MIN),
		.mask_op(mask_op),
		.wdata(req_wdata),
		.and_mask(req_and_mask),
		.or_mask(req_or_mask),
		.stage_reg(min_reg)
	);

	mbrh_stage #(
		.WIDTH(16)
	) stage_hour_i (
		.ref_clk(ref_clk),
		.rst_n(rst_n),
		.refresh(auto_reg),
		.live(rtc_hour),
		.wr(stage_wr && req_addr == `MBRH_ADDR_CLK_HOUR),
		.mask_op(mask_op),
		.wdata(req_wdata),
		.and_mask(req_and_mask),
		.or_mask(req_or_mask),
		.stage_reg(hour_reg)
	);

	// address classification
	always @* begin
		is_clk_reg = (req_addr >= `MBRH_ADDR_CLK_SEC) && (req_addr <= `MBRH_ADDR_CLK_HOUR);
		is_clk_coil = (req_addr == `MBRH_ADDR_CLK_SEC) || (req_addr == `MBRH_ADDR_CLK_MIN);
		is_read = 1'b0;
		is_write_reg = 1'b0;
		addr_ok = 1'b0;
		// reads first, then the coil and register write families
		if (req_func == `MBRH_FC_RD_DISC) begin
			is_read = 1'b1;
			addr_ok = (req_addr == `MBRH_ADDR_RUN);
		end else if (req_func == `MBRH_FC_RD_COILS) begin
			is_read = 1'b1;
			addr_ok = is_clk_coil || (req_addr == `MBRH_ADDR_FAULT);
		end else if (req_func == `MBRH_FC_RD_INPUT) begin
			is_read = 1'b1;
			addr_ok = (req_addr == `MBRH_ADDR_FAULT);
		end else if (req_func == `MBRH_FC_RD_HOLD) begin
			is_read = 1'b1;
			addr_ok = is_clk_reg;
		end else if (req_func == `MBRH_FC_WR_COIL || req_func == `MBRH_FC_WR_COILS) begin
			addr_ok = is_clk_coil || (req_addr == `MBRH_ADDR_FAULT);
		end else if (req_func == `MBRH_FC_WR_REG || req_func == `MBRH_FC_WR_REGS
			|| req_func == `MBRH_FC_RW_REGS || req_func == `MBRH_FC_MASK_WR) begin
			is_write_reg = 1'b1;
			addr_ok = is_clk_reg;
		end
	end

	// exception and read data selection, in modbus priority order
	always @* begin
		exc_next = 8'h00;
		data_next = 16'h0000;
		if (req_func != `MBRH_FC_RD_COILS && req_func != `MBRH_FC_RD_DISC
			&& req_func != `MBRH_FC_RD_HOLD && req_func != `MBRH_FC_RD_INPUT
			&& req_func != `MBRH_FC_WR_COIL && req_func != `MBRH_FC_WR_REG
			&& req_func != `MBRH_FC_WR_COILS && req_func != `MBRH_FC_WR_REGS
			&& req_func != `MBRH_FC_MASK_WR && req_func != `MBRH_FC_RW_REGS) begin
			exc_next = `MBRH_EX_FUNC;
		end else if (!addr_ok) begin
			exc_next = `MBRH_EX_ADDR;
		end else if (req_count != 16'h0001) begin
			exc_next = `MBRH_EX_VALUE;
		end else if (req_fail) begin
			exc_next = `MBRH_EX_FAIL;
		end else if (req_func == `MBRH_FC_RD_DISC) begin
			data_next = {15'h0000, run_state};
		end else if (req_func == `MBRH_FC_RD_COILS) begin
			if (req_addr == `MBRH_ADDR_FAULT)
				data_next = {15'h0000, fault_flag};
			else if (req_addr == `MBRH_ADDR_CLK_SEC)
				data_next = {15'h0000, auto_reg};
		end else if (req_func == `MBRH_FC_RD_INPUT) begin
			data_next = fault_code;
		end else if (req_func == `MBRH_FC_RD_HOLD || req_func == `MBRH_FC_RW_REGS) begin
			data_next = masked;
		end
	end

	// fault code priority: lowest code wins when several arrive at once
	always @* begin
		// assume a hit, dropped below when no source fires
		flt_hit = 1'b1;
		flt_next = `MBRH_RST_FAULT;
		if (flt_alloc)
			flt_next = `MBRH_FLT_ALLOC;
		else if (flt_csum)
			flt_next = `MBRH_FLT_CSUM;
		else if (flt_bcast)
			flt_next = `MBRH_FLT_BCAST;
		else if (flt_size)
			flt_next = `MBRH_FLT_SIZE;
		else if (flt_coils)
			flt_next = `MBRH_FLT_COILS;
		else if (flt_regs)
			flt_next = `MBRH_FLT_REGS;
		else if (flt_rw)
			flt_next = `MBRH_FLT_RW;
		else if (flt_dma)
			flt_next = `MBRH_FLT_DMA;
		else if (flt_queue)
			flt_next = `MBRH_FLT_QUEUE;
		else
			flt_hit = 1'b0;
	end

	// reply, one cycle after the request; one handler serves both ports
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			rsp_valid <= 1'b0;
			rsp_port <= 1'b0;
			rsp_func <= 8'h00;
			rsp_exc <= 8'h00;
			rsp_data <= 16'h0000;
		end else begin
			// port travels with the reply so each link gets its own answer
			rsp_valid <= req_valid;
			if (req_valid) begin
				rsp_port <= req_port;
				rsp_func <= (exc_next != 8'h00) ? (req_func | 8'h80) : req_func;
				rsp_exc <= exc_next;
				rsp_data <= data_next;
			end
		end
	end

	// fault register and flag; a new fault wins over a clearing write
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			fault_code <= `MBRH_RST_FAULT;
			fault_flag <= 1'b0;
		end else begin
			// a clearing write only counts when the request itself is clean
			if (flt_hit) begin
				fault_code <= flt_next;
				fault_flag <= 1'b1;
			end else if (req_valid && exc_next == 8'h00 && req_addr == `MBRH_ADDR_FAULT
				&& (req_func == `MBRH_FC_WR_COIL || req_func == `MBRH_FC_WR_COILS)) begin
				fault_flag <= req_wdata[0];
			end
		end
	end

	// refresh flag and apply strobe; the apply coil written with zero does nothing
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			auto_reg <= `MBRH_RST_AUTO;
			rtc_load <= 1'b0;
			rtc_set_sec <= 16'h0000;
			rtc_set_min <= 16'h0000;
			rtc_set_hour <= 16'h0000;
		end else begin
			// strobe stands for one cycle only
			rtc_load <= 1'b0;
			if (req_valid && exc_next == 8'h00) begin
				if (req_func == `MBRH_FC_WR_COIL || req_func == `MBRH_FC_WR_COILS) begin
					if (req_addr == `MBRH_ADDR_CLK_SEC)
						auto_reg <= req_wdata[0];
					else if (req_addr == `MBRH_ADDR_CLK_MIN && req_wdata[0]) begin
						rtc_load <= 1'b1;
						rtc_set_sec <= sec_reg;
						rtc_set_min <= min_reg;
						rtc_set_hour <= hour_reg;
					end
				end
			end
		end
	end

	// line index against the size of the selected store
	always @* begin
		if (prog_special)
			line_fits = ({16'h0000, prog_line} < SPC_LINES);
		else
			line_fits = ({16'h0000, prog_line} < GEN_LINES);
	end

	// program store gate: refused while running or beyond store size
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			prog_accept <= 1'b0;
			prog_refused <= 1'b0;
		end else begin
			prog_accept <= prog_valid && !run_state && line_fits;
			prog_refused <= prog_valid && (run_state || !line_fits);
		end
	end
endmodule // mbrh_handler

// one staged clock field: follows the running clock while refresh is on,
// otherwise keeps what the master wrote until it is applied
module mbrh_stage #(
	parameter WIDTH = 16
) (
	// clock and reset
	input wire ref_clk,
	input wire rst_n,
	// refresh source
	input wire refresh,
	input wire [WIDTH-1:0] live,
	// master write
	input wire wr,
	input wire mask_op,
	input wire [WIDTH-1:0] wdata,
	input wire [WIDTH-1:0] and_mask,
	input wire [WIDTH-1:0] or_mask,
	// staged value
	output reg [WIDTH-1:0] stage_reg
);
	// refresh and write never meet: the handler only writes with refresh off
	always @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			stage_reg <= {WIDTH{1'b0}};
		end else if (refresh) begin
			stage_reg <= live;
		end else if (wr) begin
			if (mask_op)
				stage_reg <= (stage_reg & and_mask) | (or_mask & ~and_mask);
			else
				stage_reg <= wdata;
		end
	end
endmodule // mbrh_stage

// ### mbrh_properties.sv
`timescale 1ns/1ns
`include "mbrh_map.vh"
module mbrh_properties #(
	parameter SPC_LINES = 8
) (
	// clock and reset
	input wire ref_clk,
	input wire nrst,
	// request
	input wire req_valid,
	input wire [7:0] req_func,
	input wire [15:0] req_addr,
	input wire [15:0] req_count,
	input wire [15:0] req_wdata,
	input wire req_fail,
	// program store
	input wire prog_valid,
	input wire prog_special,
	input wire [15:0] prog_line,
	input wire run_state,
	input wire prog_accept,
	input wire prog_refused,
	// faults
	input wire flt_alloc,
	input wire flt_csum,
	input wire flt_bcast,
	input wire flt_size,
	input wire flt_coils,
	input wire flt_regs,
	input wire flt_rw,
	input wire flt_dma,
	input wire flt_queue,
	// reply and state
	input wire rsp_valid,
	input wire [7:0] rsp_func,
	input wire [7:0] rsp_exc,
	input wire rtc_load,
	input wire [15:0] fault_code,
	input wire fault_flag
);
	// seconds read with valid function and address; the count and the fail flag still decide the answer
	wire rd_sec = req_valid && req_func == `MBRH_FC_RD_HOLD && req_addr == `MBRH_ADDR_CLK_SEC;
	wire flt_any = flt_alloc | flt_csum | flt_bcast | flt_size | flt_coils | flt_regs
		| flt_rw | flt_dma | flt_queue;
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!nrst);
	chk_req_answered: assert property (req_valid |=> rsp_valid)
		else $error("request not answered");
	chk_bad_func: assert property (req_valid && req_func == 8'h07 |=>
		rsp_exc == `MBRH_EX_FUNC && rsp_func == 8'h87) else $error("bad function accepted");
	chk_exc_echo: assert property (rsp_valid && rsp_exc != 8'h00 |-> rsp_func[7])
		else $error("exception without msb");
	chk_fail_exc: assert property (rd_sec && req_fail && req_count == 16'h0001 |=>
		rsp_exc == `MBRH_EX_FAIL) else $error("failure not reported");
	chk_csum_code: assert property (flt_csum && !flt_alloc |=>
		fault_code == `MBRH_FLT_CSUM && fault_flag) else $error("checksum fault not logged");
	chk_fault_kept: assert property (!flt_any |=> $stable(fault_code))
		else $error("fault code changed");
	chk_run_refuse: assert property (prog_valid && run_state |=>
		prog_refused && !prog_accept) else $error("program change while running");
	chk_spc_size: assert property (prog_valid && !run_state && prog_special
		&& prog_line >= SPC_LINES |=> prog_refused) else $error("special store overrun");
	chk_clock_apply: assert property (req_valid && req_func == `MBRH_FC_WR_COIL
		&& req_addr == `MBRH_ADDR_CLK_MIN && req_wdata[0] && !req_fail
		&& req_count == 16'h0001 |=> rtc_load) else $error("time not applied");
endmodule // mbrh_properties
bind mbrh_handler mbrh_properties #(.SPC_LINES(SPC_LINES)) mbrh_properties_i (.ref_clk, .nrst,
	.req_valid, .req_func, .req_addr, .req_count, .req_wdata, .req_fail, .prog_valid,
	.prog_special, .prog_line, .run_state, .prog_accept, .prog_refused, .flt_alloc, .flt_csum,
	.flt_bcast, .flt_size, .flt_coils, .flt_regs, .flt_rw, .flt_dma, .flt_queue, .rsp_valid,
	.rsp_func, .rsp_exc, .rtc_load, .fault_code, .fault_flag);

// ### mbrh_master.sv
`timescale 1ns/1ns
module mbrh_master (
	// clock and reply
	input wire ref_clk,
	input wire rsp_valid,
	// request
	output reg req_valid,
	output reg req_port,
	output reg [7:0] req_func,
	output reg [15:0] req_addr,
	output reg [15:0] req_count,
	output reg [15:0] req_wdata,
	output reg req_fail
);
	// idle until the first frame
	initial begin
		req_valid = 1'b0;
		req_port = 1'b0;
		req_func = 8'h00;
		req_addr = 16'h0000;
		req_count = 16'h0000;
		req_wdata = 16'h0000;
		req_fail = 1'b0;
	end
	// one-cycle request; released func, addr, count and data lines show inverted leftovers, port and fail stay stale
	task xfer(input [7:0] f, input [15:0] a, input [15:0] c, input [15:0] w, input fl,
		input p, output ok);
		integer n;
		begin
			@(negedge ref_clk);
			req_valid = 1'b1;
			req_port = p;
			req_func = f;
			req_addr = a;
			req_count = c;
			req_wdata = w;
			req_fail = fl;
			ok = 1'b0;
			for (n = 0; n < 4 && !ok; n = n + 1) begin
				@(negedge ref_clk);
				req_valid = 1'b0;
				req_func = ~f;
				req_addr = ~a;
				req_count = ~c;
				req_wdata = ~w;
				ok = (rsp_valid === 1'b1);
			end
		end
	endtask
endmodule // mbrh_master

// ### testbench.sv
`timescale 1ns/1ns
module testbench;
	localparam [15:0] GL = 16'h0014;
	localparam [15:0] SL = 16'h0008;
	reg ref_clk, nrst, prog_valid, prog_special, run_state, rq_fail, rq_port;
	reg [15:0] prog_line, rtc_sec, rtc_min, rtc_hour, rq_cnt;
	reg [8:0] flt;
	wire req_valid, req_port, req_fail, rsp_valid, rsp_port, rtc_load;
	wire prog_accept, prog_refused, fault_flag;
	wire [7:0] req_func, rsp_func, rsp_exc;
	wire [15:0] req_addr, req_count, req_wdata, rsp_data, rtc_set_sec, rtc_set_min;
	wire [15:0] rtc_set_hour, fault_code;
	integer failures, checks, i;
	mbrh_master mbrh_master_i (.ref_clk, .rsp_valid, .req_valid, .req_port, .req_func,
		.req_addr, .req_count, .req_wdata, .req_fail);
	mbrh_handler #(.GEN_LINES(GL), .SPC_LINES(SL)) mbrh_handler_i (.ref_clk, .nrst,
		.req_valid, .req_port, .req_func, .req_addr, .req_count, .req_wdata,
		.req_and_mask(16'h00ff), .req_or_mask(16'h0f00), .req_fail, .prog_valid, .prog_special,
		.prog_line, .flt_alloc(flt[0]), .flt_csum(flt[1]), .flt_bcast(flt[2]), .flt_size(flt[3]),
		.flt_coils(flt[4]), .flt_regs(flt[5]), .flt_rw(flt[6]), .flt_dma(flt[7]),
		.flt_queue(flt[8]), .run_state, .rtc_sec, .rtc_min, .rtc_hour, .rsp_valid, .rsp_port,
		.rsp_func, .rsp_exc, .rsp_data, .rtc_load, .rtc_set_sec, .rtc_set_min, .rtc_set_hour,
		.prog_accept, .prog_refused, .fault_code, .fault_flag);
	// free-running clock
	initial begin
		ref_clk = 1'b0;
		forever #5 ref_clk = ~ref_clk;
	end
	task give_verdict;
		begin
			$display("failures %0d checks %0d", failures, checks);
			if (failures == 0 && checks > 0)
				$display("Test passed");
			else
				$display("Test failed");
			$finish;
		end
	endtask
	task cmp(input [15:0] got, input [15:0] exp);
		begin
			checks = checks + 1;
			if (got !== exp) begin
				failures = failures + 1;
				$display("BAD %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	// one frame; data compared only under mask dm
	task rq(input [7:0] f, input [15:0] a, input [15:0] w, input [7:0] ex, input [15:0] ed,
		input [15:0] dm);
		reg ok;
		begin
			mbrh_master_i.xfer(f, a, rq_cnt, w, rq_fail, rq_port, ok);
			if (ok !== 1'b1) begin
				failures = failures + 1;
				give_verdict;
			end
			cmp({8'h00, rsp_func}, {8'h00, f | ((ex != 8'h00) ? 8'h80 : 8'h00)});
			cmp({7'h00, rsp_port, rsp_exc}, {7'h00, rq_port, ex});
			cmp(rsp_data & dm, ed & dm);
		end
	endtask
	task pg(input sp, input [15:0] ln, input acc);
		begin
			@(negedge ref_clk);
			prog_valid = 1'b1;
			prog_special = sp;
			prog_line = ln;
			@(negedge ref_clk);
			prog_valid = 1'b0;
			cmp({14'h0000, prog_accept, prog_refused}, {14'h0000, acc, ~acc});
		end
	endtask
	task t_codes;
		reg [7:0] fc [0:9];
		reg [15:0] ad [0:9];
		begin
			fc = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h0f, 8'h10, 8'h16, 8'h17};
			ad = '{16'he003, 16'hf001, 16'h8110, 16'he003, 16'he003, 16'h8112, 16'he003,
				16'h8112, 16'h8112, 16'h8112};
			for (i = 0; i < 10; i = i + 1) begin
				rq_port = i[0];
				rq(fc[i], ad[i], 16'h0000, 8'h00, 16'h0000, 16'h0000);
			end
			rq_port = 1'b0;
		end
	endtask
	task t_exc;
		begin
			rq(8'h07, 16'h8110, 16'h0000, 8'h01, 16'h0000, 16'h0000);
			rq(8'h03, 16'h0000, 16'h0000, 8'h02, 16'h0000, 16'h0000);
			rq_cnt = 16'h0002;
			rq(8'h03, 16'h8110, 16'h0000, 8'h03, 16'h0000, 16'h0000);
			rq_cnt = 16'h0001;
			rq_fail = 1'b1;
			rq(8'h03, 16'h8110, 16'h0000, 8'h04, 16'h0000, 16'h0000);
			rq_fail = 1'b0;
		end
	endtask
	// every fault source in turn, then read back and clear the flag
	task t_faults;
		begin
			for (i = 0; i < 9; i = i + 1) begin
				@(negedge ref_clk);
				flt = 9'h001 << i;
				@(negedge ref_clk);
				flt = 9'h000;
				cmp(fault_code, i[15:0] + 16'h0001);
				cmp({15'h0000, fault_flag}, 16'h0001);
			end
			rq(8'h04, 16'he003, 16'h0000, 8'h00, 16'h0009, 16'hffff);
			rq(8'h05, 16'he003, 16'h0000, 8'h00, 16'h0000, 16'h0000);
			rq(8'h01, 16'he003, 16'h0000, 8'h00, 16'h0000, 16'h0001);
			cmp(fault_code, 16'h0009);
		end
	endtask
	task t_clock;
		begin
			rq(8'h01, 16'h8110, 16'h0000, 8'h00, 16'h0001, 16'h0001);
			rq(8'h03, 16'h8111, 16'h0000, 8'h00, 16'h0022, 16'hffff);
			rq(8'h05, 16'h8110, 16'h0000, 8'h00, 16'h0000, 16'h0000);
			rq(8'h06, 16'h8110, 16'h0005, 8'h00, 16'h0000, 16'h0000);
			rq(8'h06, 16'h8111, 16'h0006, 8'h00, 16'h0000, 16'h0000);
			rq(8'h17, 16'h8111, 16'h0016, 8'h00, 16'h0006, 16'hffff);
			rq(8'h06, 16'h8112, 16'h0007, 8'h00, 16'h0000, 16'h0000);
			rtc_sec = 16'h0041;
			rq(8'h03, 16'h8112, 16'h0000, 8'h00, 16'h0007, 16'hffff);
			rq(8'h16, 16'h8112, 16'h0000, 8'h00, 16'h0000, 16'h0000);
			rq(8'h03, 16'h8112, 16'h0000, 8'h00, 16'h0f07, 16'hffff);
			rq(8'h05, 16'h8111, 16'h0001, 8'h00, 16'h0000, 16'h0000);
			cmp({15'h0000, rtc_load}, 16'h0001);
			cmp(rtc_set_sec, 16'h0005);
			cmp(rtc_set_min, 16'h0016);
			cmp(rtc_set_hour, 16'h0f07);
			rq(8'h05, 16'h8110, 16'h0001, 8'h00, 16'h0000, 16'h0000);
			rq(8'h03, 16'h8110, 16'h0000, 8'h00, 16'h0041, 16'hffff);
		end
	endtask
	task t_run;
		begin
			run_state = 1'b1;
			rq(8'h02, 16'hf001, 16'h0000, 8'h00, 16'h0001, 16'h0001);
			pg(1'b0, 16'h0000, 1'b0);
			run_state = 1'b0;
			rq(8'h02, 16'hf001, 16'h0000, 8'h00, 16'h0000, 16'h0001);
			pg(1'b0, GL - 16'h0001, 1'b1);
			pg(1'b0, GL, 1'b0);
			pg(1'b1, SL - 16'h0001, 1'b1);
			pg(1'b1, SL, 1'b0);
		end
	endtask
	// reset, then the scenarios
	initial begin
		failures = 0;
		checks = 0;
		nrst = 1'b0;
		prog_valid = 1'b0;
		prog_special = 1'b0;
		prog_line = 16'h0000;
		run_state = 1'b0;
		flt = 9'h000;
		rtc_sec = 16'h0011;
		rtc_min = 16'h0022;
		rtc_hour = 16'h0033;
		rq_cnt = 16'h0001;
		rq_fail = 1'b0;
		rq_port = 1'b0;
		repeat (12) @(negedge ref_clk);
		nrst = 1'b1;
		repeat (3) @(negedge ref_clk);
		cmp({fault_flag, fault_code[14:0]}, 16'h0000);
		t_codes;
		t_exc;
		t_faults;
		t_clock;
		t_run;
		give_verdict;
	end
endmodule // testbench
